// *** core/dma_channel_control.sv ***
// dma channel control: register file, arbitration and copy engine
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module dma_channel_control
  import dma_pkg::*;
(
  // clock and reset
  input  wire logic           clk_i,
  input  wire logic           rst_n_i,
  // ahb-lite slave
  input  wire logic           hsel_i,
  input  wire logic [31:0]    haddr_i,
  input  wire logic [1:0]     htrans_i,
  input  wire logic           hwrite_i,
  input  wire logic [31:0]    hwdata_i,
  input  wire logic           hready_i,
  output logic [31:0]         hrdata_o,
  output logic                hreadyout_o,
  output logic                hresp_o,
  // memory master port
  output logic                mem_req_o,
  output logic                mem_we_o,
  output logic [31:0]         mem_addr_o,
  output logic [1:0]          mem_size_o,
  output logic [31:0]         mem_wdata_o,
  input  wire logic [31:0]    mem_rdata_i,
  input  wire logic           mem_ack_i,
  // peripheral requests and bus lock
  input  wire logic [NCH-1:0] dreq_i,
  output logic                bus_lock_o
);
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE, ST_GAP} eng_state_e;

  logic [31:0]    src_reg  [NCH];  // source base addresses
  logic [31:0]    dst_reg  [NCH];  // destination base addresses
  logic [15:0]    len_reg  [NCH];  // transfer lengths
  logic [15:0]    ctrl_reg [NCH];  // control registers
  logic [15:0]    idx_reg  [NCH];  // item indices
  eng_state_e     state_reg;       // engine state
  logic [CHW-1:0] cur_reg;         // channel owning the engine
  logic           resume_reg;      // gap returns to a fill
  logic           mem_req_reg;     // memory request held
  logic           mem_we_reg;      // memory write flag
  logic [31:0]    mem_addr_reg;    // memory address
  logic [1:0]     mem_size_reg;    // memory item width
  logic [31:0]    data_reg;        // fetched item, reused by fill
  logic           lock_reg;        // bus lock toward other masters
  logic           wr_pend;         // ahb write data phase
  logic           rd_pend;         // ahb read wait cycle
  logic [5:0]     ap_off;          // latched register offset
  logic [CHW-1:0] ap_ch;           // latched channel number
  logic [31:0]    hrdata_reg;      // read data
  logic           hready_reg;      // ready toward master
  logic [31:0]    rd_val;          // read mux
  logic           ahb_take;        // address phase taken

  // ahb address phase decode
  assign ahb_take = hsel_i && htrans_i[1] && hready_i;

  // address phase capture, reads take one wait cycle
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      ap_off  <= '0;
      ap_ch   <= '0;
    end else begin
      wr_pend <= ahb_take && hwrite_i;
      rd_pend <= ahb_take && !hwrite_i;
      if (ahb_take) begin
        ap_off <= haddr_i[5:0];
        ap_ch  <= haddr_i[CH_LSB +: CHW];
      end
    end
  end

  // read mux, unmapped offsets read zero
  always_comb begin
    rd_val = '0;
    case (ap_off)
      OFF_SRC:  rd_val = src_reg[ap_ch];
      OFF_DST:  rd_val = dst_reg[ap_ch];
      OFF_LEN:  rd_val = {16'h0000, len_reg[ap_ch]};
      OFF_CTRL: rd_val = {16'h0000, ctrl_reg[ap_ch]};
      OFF_ITEM: rd_val = {16'h0000, idx_reg[ap_ch]};
      default:  rd_val = '0;
    endcase
  end

  // read data and ready flops
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      hrdata_reg <= '0;
      hready_reg <= 1'b1;
    end else begin
      hready_reg <= !(ahb_take && !hwrite_i);
      if (rd_pend) hrdata_reg <= rd_val;
    end
  end

  assign hrdata_o    = hrdata_reg;
  assign hreadyout_o = hready_reg;
  assign hresp_o     = 1'b0;

  // current channel fields
  logic [15:0] cc;       // control of owning channel
  logic [1:0]  cwid;     // its item width
  logic        fill;     // fill mode
  logic        trig;     // peripheral trigger mode
  logic        gap_en;   // yield gap after store
  logic        last;     // current item is the final one
  logic        wr_done;  // store acknowledged
  logic [31:0] step;     // byte offset of current item
  logic [31:0] src_addr; // next source address
  logic [31:0] dst_addr; // next destination address

  assign cc       = ctrl_reg[cur_reg];
  assign cwid     = cc[WID_MSB:WID_LSB];
  assign fill     = cc[CTRL_FILL];
  assign trig     = cc[CTRL_TRIG];
  assign gap_en   = cc[CTRL_YIELD] && !trig;
  assign last     = idx_reg[cur_reg] == len_reg[cur_reg];
  assign wr_done  = state_reg == ST_WRITE && mem_req_reg && mem_ack_i;
  assign step     = 32'(idx_reg[cur_reg]) << cwid;
  // fill never steps the source, so a triggered fill refetches the same first item
  assign src_addr = src_reg[cur_reg] + ((cc[CTRL_SINC] && !fill) ? step : '0);
  assign dst_addr = dst_reg[cur_reg] + (cc[CTRL_DINC] ? step : '0);

  // channel readiness and request sensing
  logic [NCH-1:0]      pend;   // pending peripheral request
  logic [NCH-1:0]      ready;  // channel wants the bus
  logic [NCH-1:0][2:0] prio;   // channel priorities
  logic                gnt_any;
  logic [CHW-1:0]      gnt_idx;

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    dma_req_sense u_sense (
      .clk_i       (clk_i),
      .rst_n_i     (rst_n_i),
      .dreq_i      (dreq_i[g]),
      .edge_mode_i (ctrl_reg[g][CTRL_SENSE]),
      .served_i    (wr_done && cur_reg == CHW'(g)),
      .pend_o      (pend[g])
    );
    assign prio[g]  = ctrl_reg[g][PRIO_MSB:PRIO_LSB];
    // immediate start or wait for peripheral request
    assign ready[g] = ctrl_reg[g][CTRL_ON]
                   && ctrl_reg[g][WID_MSB:WID_LSB] != W_RSVD
                   && (ctrl_reg[g][CTRL_TRIG] ? pend[g] : 1'b1);
  end

  channel_priority_arb u_arb (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .req_i     (ready),
    .prio_i    (prio),
    .gnt_any_o (gnt_any),
    .gnt_idx_o (gnt_idx)
  );

  // software registers without hardware update
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < NCH; i++) begin
        src_reg[i] <= '0;
        dst_reg[i] <= '0;
        len_reg[i] <= '0;
      end
    end else if (wr_pend) begin
      case (ap_off)
        OFF_SRC: src_reg[ap_ch] <= hwdata_i;
        OFF_DST: dst_reg[ap_ch] <= hwdata_i;
        OFF_LEN: len_reg[ap_ch] <= hwdata_i[15:0];
        default: ;
      endcase
    end
  end

  // control: hardware clears enable, a software write wins
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < NCH; i++) ctrl_reg[i] <= CTRL_RST;
    end else begin
      if (wr_done && last && !(cc[CTRL_CIRC] && trig))
        ctrl_reg[cur_reg][CTRL_ON] <= 1'b0;
      if (wr_pend && ap_off == OFF_CTRL)
        ctrl_reg[ap_ch] <= hwdata_i[15:0] & CTRL_WMASK;
    end
  end

  // item index, rewinds on completion in both modes
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < NCH; i++) idx_reg[i] <= '0;
    end else if (wr_done) begin
      idx_reg[cur_reg] <= last ? '0 : idx_reg[cur_reg] + 16'h0001;
    end
  end

  // copy engine sequencing
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg  <= ST_IDLE;
      cur_reg    <= '0;
      resume_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (gnt_any) begin
            cur_reg   <= gnt_idx;
            state_reg <= ST_READ;
          end
        end
        ST_READ: begin
          if (mem_req_reg && mem_ack_i) state_reg <= ST_WRITE;
        end
        ST_WRITE: begin
          if (wr_done) begin
            resume_reg <= fill && !last;
            if (gap_en) begin
              state_reg <= ST_GAP;
            end else if (last || trig) begin
              state_reg <= ST_IDLE;
            end else if (fill) begin
              state_reg <= ST_WRITE;
            end else begin
              state_reg <= ST_READ;
            end
          end
        end
        ST_GAP: begin
          // fill keeps the engine, others re-arbitrate in the gap itself
          if (!resume_reg && gnt_any) cur_reg <= gnt_idx;
          state_reg <= resume_reg ? ST_WRITE : (gnt_any ? ST_READ : ST_IDLE);
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // memory port, request held until acknowledged
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mem_req_reg  <= 1'b0;
      mem_we_reg   <= 1'b0;
      mem_addr_reg <= '0;
      mem_size_reg <= W_BYTE;
    end else if (mem_req_reg) begin
      if (mem_ack_i) mem_req_reg <= 1'b0;
    end else if (state_reg == ST_READ || state_reg == ST_WRITE) begin
      mem_req_reg  <= 1'b1;
      mem_we_reg   <= state_reg == ST_WRITE;
      mem_addr_reg <= state_reg == ST_WRITE ? dst_addr : src_addr;
      mem_size_reg <= cwid;
    end
  end

  // fetched item, kept for every fill store
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      data_reg <= '0;
    end else if (state_reg == ST_READ && mem_req_reg && mem_ack_i) begin
      data_reg <= mem_rdata_i;
    end
  end

  // lock lower masters out in untriggered blocking or fill transfers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      lock_reg <= 1'b0;
    end else begin
      lock_reg <= (state_reg == ST_READ || state_reg == ST_WRITE)
               && !trig && (!cc[CTRL_YIELD] || fill);
    end
  end

  assign mem_req_o   = mem_req_reg;
  assign mem_we_o    = mem_we_reg;
  assign mem_addr_o  = mem_addr_reg;
  assign mem_size_o  = mem_size_reg;
  assign mem_wdata_o = data_reg;
  assign bus_lock_o  = lock_reg;

  // checks
  logic ctrl_wr;  // software writes the owning control register
  assign ctrl_wr = wr_pend && ap_off == OFF_CTRL && ap_ch == cur_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_fill_hold;
    wr_done && fill && !last && !gap_en |=> state_reg == ST_WRITE ##1 mem_req_o && mem_we_o;
  endproperty
  a_fill_hold: assert property (p_fill_hold)
    else $error("fill did not keep storing");
  property p_fill_data;
    $rose(mem_req_o) && mem_we_o && fill |-> mem_wdata_o == $past(data_reg);
  endproperty
  a_fill_data: assert property (p_fill_data)
    else $error("fill store data changed");
  property p_gap;
    wr_done && gap_en |=> state_reg == ST_GAP ##1 !mem_req_o;
  endproperty
  a_gap: assert property (p_gap)
    else $error("no idle cycle after store");
  property p_back;
    wr_done && !gap_en && !trig && !fill && !last |=> state_reg == ST_READ ##1 mem_req_o;
  endproperty
  a_back: assert property (p_back)
    else $error("blocking copy not back to back");
  property p_stop;
    wr_done && last && !(cc[CTRL_CIRC] && trig) && !ctrl_wr
      |=> !ctrl_reg[$past(cur_reg)][CTRL_ON];
  endproperty
  a_stop: assert property (p_stop)
    else $error("enable not cleared at end");
  property p_circ;
    wr_done && last && cc[CTRL_CIRC] && trig && !ctrl_wr
      |=> ctrl_reg[cur_reg][CTRL_ON] && idx_reg[cur_reg] == 16'h0000;
  endproperty
  a_circ: assert property (p_circ)
    else $error("circular rewind wrong");
  c_fill: cover property (wr_done && fill && last);
  c_yield: cover property (state_reg == ST_GAP);
  c_circ: cover property (wr_done && last && cc[CTRL_CIRC] && trig);
endmodule : dma_channel_control
`default_nettype wire

// *** core/dma_pkg.sv ***
// shared constants for the dma channel control block
package dma_pkg;
  localparam int NCH = 4;                   // number of channels
  localparam int CHW = 2;                   // channel number width
  // printed register indices; byte address = 4 * (index - base)
  localparam logic [31:0] BASE_IDX   = 32'h5000_3600;
  localparam logic [31:0] SRC_IDX    = 32'h5000_3600;
  localparam logic [31:0] DST_IDX    = 32'h5000_3604;
  localparam logic [31:0] LEN_IDX    = 32'h5000_360a;
  localparam logic [31:0] CTRL_IDX   = 32'h5000_360c;
  localparam logic [31:0] ITEM_IDX   = 32'h5000_360e;
  localparam logic [31:0] STRIDE_IDX = 32'h0000_0010;
  // byte offsets inside one channel window
  localparam logic [5:0] OFF_SRC  = 6'((SRC_IDX - BASE_IDX) << 2);
  localparam logic [5:0] OFF_DST  = 6'((DST_IDX - BASE_IDX) << 2);
  localparam logic [5:0] OFF_LEN  = 6'((LEN_IDX - BASE_IDX) << 2);
  localparam logic [5:0] OFF_CTRL = 6'((CTRL_IDX - BASE_IDX) << 2);
  localparam logic [5:0] OFF_ITEM = 6'((ITEM_IDX - BASE_IDX) << 2);
  localparam int CH_LSB = $clog2(32'(STRIDE_IDX << 2)); // channel field
  // control register fields
  localparam int CTRL_SENSE = 13;
  localparam int CTRL_FILL  = 12;
  localparam int CTRL_YIELD = 11;
  localparam int PRIO_MSB   = 10;
  localparam int PRIO_LSB   = 8;
  localparam int CTRL_CIRC  = 7;
  localparam int CTRL_SINC  = 6;
  localparam int CTRL_DINC  = 5;
  localparam int CTRL_TRIG  = 4;
  localparam int WID_MSB    = 2;
  localparam int WID_LSB    = 1;
  localparam int CTRL_ON    = 0;
  localparam logic [15:0] CTRL_WMASK = 16'h3fff;
  localparam logic [15:0] CTRL_RST   = 16'h0000;
  // item width codes
  localparam logic [1:0] W_BYTE = 2'h0;
  localparam logic [1:0] W_HALF = 2'h1;
  localparam logic [1:0] W_WORD = 2'h2;
  localparam logic [1:0] W_RSVD = 2'h3;
endpackage : dma_pkg

// *** core/dma_req_sense.sv ***
// peripheral request synchroniser and level/edge sensing for one channel
`timescale 1ns/1ns
`default_nettype none
module dma_req_sense (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // request pin and mode
  input  wire logic dreq_i,
  input  wire logic edge_mode_i,
  input  wire logic served_i,
  // pending request
  output logic      pend_o
);
  logic s1_reg;    // first sync stage
  logic s2_reg;    // second sync stage
  logic s3_reg;    // delayed copy for edge detect
  logic hold_reg;  // caught rising edge
  logic rise;      // rising edge seen

  // two-flop synchroniser plus delay stage
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= dreq_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  assign rise = s2_reg && !s3_reg;

  // edge latch, a new edge wins over the serve clear
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      hold_reg <= 1'b0;
    end else if (rise) begin
      hold_reg <= 1'b1;
    end else if (served_i) begin
      hold_reg <= 1'b0;
    end
  end

  // level mode follows the pin, edge mode the latch
  assign pend_o = edge_mode_i ? hold_reg : s2_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_edge_pend;
    rise && edge_mode_i |=> hold_reg;
  endproperty
  a_edge_pend: assert property (p_edge_pend)
    else $error("rising request edge not latched");
  c_edge: cover property (rise && edge_mode_i);
endmodule : dma_req_sense
`default_nettype wire

// *** core/channel_priority_arb.sv ***
// priority arbiter, lower channel number wins a tie
`timescale 1ns/1ns
`default_nettype none
module channel_priority_arb
  import dma_pkg::*;
(
  // clock and reset, used by checks only
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  // requests and priorities
  input  wire logic [NCH-1:0]        req_i,
  input  wire logic [NCH-1:0][2:0]   prio_i,
  // grant
  output logic                       gnt_any_o,
  output logic [CHW-1:0]             gnt_idx_o
);
  logic [2:0] best;  // best priority so far

  // scan upward, only a strictly higher value displaces
  always_comb begin
    gnt_any_o = 1'b0;
    gnt_idx_o = '0;
    best      = '0;
    for (int i = 0; i < NCH; i++) begin
      if (req_i[i] && (!gnt_any_o || prio_i[i] > best)) begin
        gnt_any_o = 1'b1;
        gnt_idx_o = CHW'(i);
        best      = prio_i[i];
      end
    end
  end

  logic hi_seen;   // some request outranks grant
  logic tie_seen;  // equal request with lower number

  // check helpers
  always_comb begin
    hi_seen  = 1'b0;
    tie_seen = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      if (req_i[i] && prio_i[i] > prio_i[gnt_idx_o]) hi_seen = 1'b1;
      if (req_i[i] && prio_i[i] == prio_i[gnt_idx_o] && CHW'(i) < gnt_idx_o)
        tie_seen = 1'b1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_prio_max;
    gnt_any_o |-> req_i[gnt_idx_o] && !hi_seen;
  endproperty
  a_prio_max: assert property (p_prio_max)
    else $error("grant not to highest priority");
  property p_tie_low;
    gnt_any_o |-> !tie_seen;
  endproperty
  a_tie_low: assert property (p_tie_low)
    else $error("tie not won by lower channel");
  c_tie: cover property (req_i[0] && req_i[1] && prio_i[0] == prio_i[1]);
endmodule : channel_priority_arb
`default_nettype wire

// *** sim/dma_mem_model.sv ***
// memory model answering the channel's fetch and store requests
`timescale 1ns/1ns
`default_nettype none
module dma_mem_model (
  // clock
  input  wire logic        clk_i,
  // request side
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [1:0]  size_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  lat_i,
  // answer side
  output logic [31:0]      rdata_o,
  output logic             ack_o
);
  logic [7:0] mem [256];  // byte store, preloaded by the bench
  logic [3:0] wait_q;     // cycles already waited
  int         nb;         // bytes in one item

  initial begin
    ack_o   = 1'b0;
    rdata_o = 32'h0000_0000;
    wait_q  = 4'h0;
  end

  // answer after lat_i cycles; data lines toggle when not answering
  always @(posedge clk_i) begin
    nb = 1 << size_i;
    ack_o   <= 1'b0;
    rdata_o <= ~rdata_o;
    if (ack_o || !req_i) begin
      wait_q <= 4'h0;
    end else if (wait_q < lat_i) begin
      wait_q <= wait_q + 4'h1;
    end else begin
      ack_o <= 1'b1;
      for (int i = 0; i < 4; i++) begin
        if (we_i && i < nb) mem[8'(addr_i[7:0] + i)] <= wdata_i[8*i +: 8];
        rdata_o[8*i +: 8] <= (i < nb) ? mem[8'(addr_i[7:0] + i)] : 8'h00;
      end
    end
  end
endmodule : dma_mem_model
`default_nettype wire

// *** sim/tb_dma_channel_control.sv ***
// self-checking bench for the dma channel control block
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) chk(32'(a), 32'(b))
module tb_dma_channel_control;
  import dma_pkg::*;
  logic        clk_i, rst_n_i;              // clock and reset
  logic        hsel, hwrite, hready, hresp; // ahb control
  logic [1:0]  htrans;                      // ahb transfer type
  logic [31:0] haddr, hwdata, hrdata, r;    // ahb address, data, read result
  logic        m_req, m_we, m_ack, lock;    // memory handshake and lock
  logic [31:0] m_addr, m_wd, m_rd;          // memory address and data
  logic [1:0]  m_size;                      // memory item size
  logic [3:0]  dreq, lat;                   // peripheral requests, latency
  logic        last_st, lock_seen;          // monitor flags
  logic [7:0]  fq[$];                       // fetch addresses seen
  int          n_errors, cmp_count, cyc, n_fetch, lo, gmin, gb, f0; // counters

  dma_channel_control i_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .mem_req_o(m_req), .mem_we_o(m_we), .mem_addr_o(m_addr), .mem_size_o(m_size),
    .mem_wdata_o(m_wd), .mem_rdata_i(m_rd), .mem_ack_i(m_ack),
    .dreq_i(dreq), .bus_lock_o(lock));

  dma_mem_model i_mem (
    .clk_i(clk_i), .req_i(m_req), .we_i(m_we), .addr_i(m_addr), .size_i(m_size),
    .wdata_i(m_wd), .lat_i(lat), .rdata_o(m_rd), .ack_o(m_ack));

  // free-running clock
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // fetch log, smallest gap after a store, run limit
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (lock) lock_seen <= 1'b1;
    if (m_ack) last_st <= m_we;
    if (m_ack && !m_we) begin
      n_fetch <= n_fetch + 1;
      fq.push_back(m_addr[7:0]);
    end
    if (!m_req) lo <= lo + 1;
    else if (lo != 0) begin
      if (last_st && lo < gmin) gmin <= lo;
      lo <= 0;
    end
    if (cyc == 40000) begin
      n_errors++;
      complete_run();
    end
  end

  // compare and count
  function automatic void chk(input logic [31:0] a, input logic [31:0] b);
    cmp_count++;
    if (a !== b) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b);
    end
  endfunction : chk

  // initial memory pattern
  function automatic logic [7:0] p(input int i);
    return 8'(i) ^ 8'h5a;
  endfunction : p

  // one single ahb transfer, address phase then data phase
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h00_0000, a};
    hwrite <= w;
    do @(posedge clk_i); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_i); while (hready !== 1'b1);
    r = hrdata;
  endtask : ahb

  // program one channel, control word last
  task automatic cfg(input logic [1:0] c, input logic [15:0] ctl, input logic [7:0] s,
                     input logic [7:0] d, input logic [15:0] n);
    ahb(1'b1, {c, OFF_SRC}, {24'h00_0000, s});
    ahb(1'b1, {c, OFF_DST}, {24'h00_0000, d});
    ahb(1'b1, {c, OFF_LEN}, {16'h0000, n});
    ahb(1'b1, {c, OFF_CTRL}, {16'h0000, ctl});
  endtask : cfg

  // poll until the channel clears its enable bit
  task automatic waitoff(input logic [1:0] c);
    repeat (200) begin
      ahb(1'b0, {c, OFF_CTRL}, 32'h0000_0000);
      if (r[CTRL_ON] === 1'b0) break;
    end
  endtask : waitoff

  // one request pulse on channel one
  task automatic pulse();
    dreq[1] <= 1'b1;
    repeat (20) @(posedge clk_i);
    dreq[1] <= 1'b0;
    repeat (20) @(posedge clk_i);
  endtask : pulse

  // counts, verdict and end of run
  task automatic complete_run();
    $display("checks=%0d errors=%0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  // main sequence
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, dreq, lat, last_st, lock_seen} = '0;
    {n_errors, cmp_count, cyc, n_fetch, lo} = '0;
    gmin = 99;
    rst_n_i = 1'b0;
    for (int i = 0; i < 256; i++) i_mem.mem[i] = p(i);
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    // reset value, reserved, read-only and unmapped places
    ahb(1'b0, {2'h0, OFF_CTRL}, 0); `CHK(r, 0);
    ahb(1'b1, {2'h0, OFF_CTRL}, 32'h0000_c700);
    ahb(1'b0, {2'h0, OFF_CTRL}, 0); `CHK(r, 32'h0000_0700);
    ahb(1'b1, {2'h0, OFF_LEN}, 32'h0001_abcd);
    ahb(1'b0, {2'h0, OFF_LEN}, 0); `CHK(r, 32'h0000_abcd);
    ahb(1'b1, {2'h0, OFF_ITEM}, 32'h0000_0005);
    ahb(1'b0, {2'h0, OFF_ITEM}, 0); `CHK(r, 0);
    ahb(1'b0, 8'h3c, 0); `CHK(r, 0);
    `CHK(hresp, 0);
    // blocking word copy, three items, slow memory
    lat <= 4'h2;
    lock_seen = 1'b0;
    cfg(2'h0, 16'h0065, 8'h00, 8'h40, 16'h0002);
    waitoff(2'h0);
    gb = gmin;
    for (int k = 0; k < 13; k++) `CHK(i_mem.mem[64+k], p(k < 12 ? k : 64 + k));
    ahb(1'b0, {2'h0, OFF_CTRL}, 0); `CHK(r, 32'h0000_0064);
    ahb(1'b0, {2'h0, OFF_ITEM}, 0); `CHK(r, 0);
    `CHK(lock_seen, 1);
    // yielding copy adds one idle cycle after each store
    gmin = 99;
    lock_seen = 1'b0;
    cfg(2'h0, 16'h0865, 8'h80, 8'hc0, 16'h0001);
    waitoff(2'h0);
    `CHK(gmin, gb + 1);
    `CHK(lock_seen, 0);
    for (int k = 0; k < 8; k++) `CHK(i_mem.mem[192+k], p(128 + k));
    // half items, source held, destination stepping
    lat <= 4'h0;
    cfg(2'h0, 16'h0023, 8'h10, 8'h20, 16'h0001);
    waitoff(2'h0);
    for (int k = 0; k < 5; k++) `CHK(i_mem.mem[32+k], p(k == 4 ? 36 : 16 + k % 2));
    // reserved width never requests the bus
    f0 = n_fetch;
    cfg(2'h2, 16'h0007, 8'h00, 8'he0, 16'h0000);
    repeat (10) @(posedge clk_i);
    `CHK(n_fetch, f0);
    ahb(1'b1, {2'h2, OFF_CTRL}, 0);
    // fill: one fetch, value stored everywhere, bus locked
    lock_seen = 1'b0;
    f0 = n_fetch;
    cfg(2'h0, 16'h1061, 8'h30, 8'h50, 16'h0003);
    waitoff(2'h0);
    for (int k = 0; k < 5; k++) `CHK(i_mem.mem[80+k], p(k < 4 ? 48 : 84));
    `CHK(n_fetch - f0, 1);
    `CHK(lock_seen, 1);
    // two triggered channels released together, higher priority first
    lat <= 4'h1;
    cfg(2'h0, 16'h0115, 8'h60, 8'h70, 16'h0000);
    cfg(2'h1, 16'h0515, 8'h64, 8'h74, 16'h0000);
    f0 = n_fetch;
    repeat (10) @(posedge clk_i);
    `CHK(n_fetch, f0);
    fq.delete();
    dreq <= 4'h3;
    waitoff(2'h0);
    waitoff(2'h1);
    `CHK(fq[0], 8'h64);
    `CHK(fq[1], 8'h60);
    // equal priority, lower channel number first
    dreq <= 4'h0;
    cfg(2'h2, 16'h0315, 8'h68, 8'h78, 16'h0000);
    cfg(2'h3, 16'h0315, 8'h6c, 8'h7c, 16'h0000);
    fq.delete();
    dreq <= 4'hc;
    waitoff(2'h2);
    waitoff(2'h3);
    `CHK(fq[0], 8'h68);
    dreq <= 4'h0;
    // edge sensing: one item per rising edge
    cfg(2'h1, 16'h2071, 8'h90, 8'ha0, 16'h0002);
    pulse();
    ahb(1'b0, {2'h1, OFF_ITEM}, 0); `CHK(r, 1);
    ahb(1'b0, {2'h1, OFF_CTRL}, 0); `CHK(r, 32'h0000_2071);
    pulse();
    pulse();
    waitoff(2'h1);
    for (int k = 0; k < 4; k++) `CHK(i_mem.mem[160+k], p(k < 3 ? 144 + k : 163));
    // circular: enable kept, transfer restarts
    f0 = n_fetch;
    cfg(2'h3, 16'h0091, 8'hb0, 8'hb4, 16'h0000);
    dreq[3] <= 1'b1;
    repeat (60) @(posedge clk_i);
    `CHK(n_fetch - f0 > 2, 1);
    ahb(1'b0, {2'h3, OFF_CTRL}, 0); `CHK(r, 32'h0000_0091);
    dreq[3] <= 1'b0;
    repeat (20) @(posedge clk_i);
    ahb(1'b1, {2'h3, OFF_CTRL}, 0);
    complete_run();
  end
endmodule : tb_dma_channel_control
`default_nettype wire
